// ===== clk_gate_pkg.sv
package clk_gate_pkg;

  // =====================================================================
  // block placement and register offsets
  // =====================================================================
  localparam logic [31:0] BLOCK_BASE = 32'h400f_e000;
  localparam logic [11:0] OFF_RUN_GATE = 12'h104;
  localparam logic [11:0] OFF_SLEEP_GATE = 12'h114;
  localparam logic [11:0] OFF_DEEP_GATE = 12'h124;
  localparam logic [11:0] OFF_MODE_CFG = 12'h180;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h184;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h188;

  // =====================================================================
  // field layout and reset values
  // =====================================================================
  localparam logic [31:0] GATE_RW_MASK = 32'h0107_1133;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam int AUTO_SLEEP_BIT = 0;
  localparam logic AUTO_SLEEP_RESET = 1'h0;
  localparam int IRQ_W = 2;
  localparam int IRQ_ACCESS_FAULT = 0;
  localparam int IRQ_BAD_ADDRESS = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // unit order: async0, async1, sync0, sync1, quad0, two_wire0, gp0..gp2, analog_comparator_0_gate
  localparam int UNIT_COUNT = 10;
  localparam int UNIT_BIT [UNIT_COUNT] = '{0, 1, 4, 5, 8, 12, 16, 17, 18, 24};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;

  // gather the ten gate bits of a register word into unit order
  function automatic logic [UNIT_COUNT-1:0] pack_units(input logic [31:0] word);
    logic [UNIT_COUNT-1:0] units;
    units = '0;
    for (int k = 0; k < UNIT_COUNT; k++) begin
      units[k] = word[UNIT_BIT[k]];
    end
    return units;
  endfunction : pack_units

endpackage : clk_gate_pkg

// ===== unit_clock_enable.sv
`timescale 1ns/100ps
`default_nettype none

module unit_clock_enable #(
  parameter int UNITS = 10
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic [UNITS-1:0] en_i, // requested unit enables
  output logic [UNITS-1:0] en_o // registered, glitch-free unit enables
);

  logic [UNITS-1:0] next_en;

  // =====================================================================
  // enable register
  // =====================================================================
  // a flop output never glitches, so units may use it as a clock enable
  always_comb begin
    next_en = en_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      en_o <= '0;
    end else begin
      en_o <= next_en;
    end
  end

  chk_enable_reset_off: assert property (@(posedge clock_i) $fell(rst_i) |-> en_o == '0)
    else $error("unit enables not off after reset");

endmodule : unit_clock_enable

`default_nettype wire

// ===== peripheral_access_guard.sv
`timescale 1ns/100ps
`default_nettype none

module peripheral_access_guard #(
  parameter int UNITS = 10
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic [UNITS-1:0] gate_i, // current unit enables
  input wire logic req_i, // access to a unit is presented
  input wire logic [3:0] unit_i, // index of the addressed unit
  output logic grant_o, // access may complete normally
  output logic fault_o // access must end in a bus fault
);

  if (UNITS > 16) begin : g_bad_units
    $error("unit index is only four bits wide");
  end

  logic unit_on;

  // =====================================================================
  // access check
  // =====================================================================
  always_comb begin
    unit_on = 1'b0;
    if (int'(unit_i) < UNITS) begin
      unit_on = gate_i[unit_i];
    end
    grant_o = req_i && unit_on;
    fault_o = req_i && !unit_on;
  end

  chk_gated_faults: assert property (@(posedge clock_i) disable iff (rst_i)
      (req_i && int'(unit_i) < UNITS && !gate_i[unit_i]) |-> (fault_o && !grant_o))
    else $error("access to a gated unit was not faulted");

endmodule : peripheral_access_guard

`default_nettype wire

// ===== run_mode_clock_gate_bank1.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module run_mode_clock_gate_bank1 #(
  parameter int ADDR_W = 12,
  parameter int UNITS = 10
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic [ADDR_W-1:0] awaddr_i, // write address
  input wire logic awvalid_i, // write address valid
  output logic awready_o, // write address ready
  input wire logic [31:0] wdata_i, // write data
  input wire logic [3:0] wstrb_i, // write byte strobes
  input wire logic wvalid_i, // write data valid
  output logic wready_o, // write data ready
  output logic [1:0] bresp_o, // write response
  output logic bvalid_o, // write response valid
  input wire logic bready_i, // write response ready
  input wire logic [ADDR_W-1:0] araddr_i, // read address
  input wire logic arvalid_i, // read address valid
  output logic arready_o, // read address ready
  output logic [31:0] rdata_o, // read data
  output logic [1:0] rresp_o, // read response
  output logic rvalid_o, // read data valid
  input wire logic rready_i, // read data ready
  input wire logic sleep_i, // system is in sleep
  input wire logic deep_sleep_i, // system is in deep sleep
  input wire logic periph_req_i, // access to a peripheral unit
  input wire logic [3:0] periph_unit_i, // addressed unit index
  output logic periph_grant_o, // access proceeds normally
  output logic periph_fault_o, // access gets a bus fault
  output logic [UNITS-1:0] unit_clk_en_o, // per-unit clock enables
  output logic irq_o // level interrupt
);

  if (UNITS != clk_gate_pkg::UNIT_COUNT || ADDR_W < 12 || ADDR_W > 32) begin : g_bad_params
    $error("unsupported unit count or address width");
  end

  // =====================================================================
  // state
  // =====================================================================
  clk_gate_pkg::wr_state_t wr_state, next_wr_state;
  clk_gate_pkg::rd_state_t rd_state, next_rd_state;
  logic aw_held, next_aw_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] bresp, next_bresp;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [31:0] run_gate, next_run_gate;
  logic [31:0] sleep_gate, next_sleep_gate;
  logic [31:0] deep_gate, next_deep_gate;
  logic auto_sleep_gating_select, next_auto_sleep_gating_select;
  logic [clk_gate_pkg::IRQ_W-1:0] irq_status, next_irq_status;
  logic [clk_gate_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;

  logic aw_take, w_take, ar_take, do_write, wr_hit, rd_hit;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [clk_gate_pkg::IRQ_W-1:0] irq_set, irq_clear;
  logic [UNITS-1:0] want_en;

  // =====================================================================
  // helpers
  // =====================================================================
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    return a[ADDR_W-1:2] == (ADDR_W-2)'(off[11:2]);
  endfunction : is_reg

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return is_reg(a, clk_gate_pkg::OFF_RUN_GATE) || is_reg(a, clk_gate_pkg::OFF_SLEEP_GATE)
      || is_reg(a, clk_gate_pkg::OFF_DEEP_GATE) || is_reg(a, clk_gate_pkg::OFF_MODE_CFG)
      || is_reg(a, clk_gate_pkg::OFF_IRQ_STATUS) || is_reg(a, clk_gate_pkg::OFF_IRQ_MASK);
  endfunction : is_mapped

  // byte-lane merge; gate registers then drop the reserved bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = val[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // =====================================================================
  // bus slave and register file
  // =====================================================================
  always_comb begin
    next_wr_state = wr_state;
    next_rd_state = rd_state;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp = bresp;
    next_rdata = rdata;
    next_rresp = rresp;
    next_run_gate = run_gate;
    next_sleep_gate = sleep_gate;
    next_deep_gate = deep_gate;
    next_auto_sleep_gating_select = auto_sleep_gating_select;
    next_irq_mask = irq_mask;
    irq_clear = '0;

    awready_o = (wr_state == clk_gate_pkg::WR_IDLE) && !aw_held;
    wready_o = (wr_state == clk_gate_pkg::WR_IDLE) && !w_held;
    arready_o = (rd_state == clk_gate_pkg::RD_IDLE);
    aw_take = awvalid_i && awready_o;
    w_take = wvalid_i && wready_o;
    ar_take = arvalid_i && arready_o;
    wr_addr = aw_held ? aw_addr : awaddr_i;
    wr_data = w_held ? w_data : wdata_i;
    wr_strb = w_held ? w_strb : wstrb_i;
    do_write = (aw_held || aw_take) && (w_held || w_take);
    wr_hit = is_mapped(wr_addr);
    rd_hit = is_mapped(araddr_i);

    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_wr_state = clk_gate_pkg::WR_RESP;
      next_bresp = wr_hit ? clk_gate_pkg::RESP_OKAY : clk_gate_pkg::RESP_SLVERR;
      if (is_reg(wr_addr, clk_gate_pkg::OFF_RUN_GATE)) begin
        next_run_gate = merge(run_gate, wr_data, wr_strb) & clk_gate_pkg::GATE_RW_MASK;
      end
      if (is_reg(wr_addr, clk_gate_pkg::OFF_SLEEP_GATE)) begin
        next_sleep_gate = merge(sleep_gate, wr_data, wr_strb) & clk_gate_pkg::GATE_RW_MASK;
      end
      if (is_reg(wr_addr, clk_gate_pkg::OFF_DEEP_GATE)) begin
        next_deep_gate = merge(deep_gate, wr_data, wr_strb) & clk_gate_pkg::GATE_RW_MASK;
      end
      if (is_reg(wr_addr, clk_gate_pkg::OFF_MODE_CFG) && wr_strb[0]) begin
        next_auto_sleep_gating_select = wr_data[clk_gate_pkg::AUTO_SLEEP_BIT];
      end
      if (is_reg(wr_addr, clk_gate_pkg::OFF_IRQ_STATUS) && wr_strb[0]) begin
        irq_clear = wr_data[clk_gate_pkg::IRQ_W-1:0];
      end
      if (is_reg(wr_addr, clk_gate_pkg::OFF_IRQ_MASK) && wr_strb[0]) begin
        next_irq_mask = wr_data[clk_gate_pkg::IRQ_W-1:0];
      end
    end else begin
      if (aw_take) begin
        next_aw_held = 1'b1;
        next_aw_addr = awaddr_i;
      end
      if (w_take) begin
        next_w_held = 1'b1;
        next_w_data = wdata_i;
        next_w_strb = wstrb_i;
      end
    end
    if (wr_state == clk_gate_pkg::WR_RESP && bready_i) begin
      next_wr_state = clk_gate_pkg::WR_IDLE;
    end

    if (ar_take) begin
      next_rd_state = clk_gate_pkg::RD_RESP;
      next_rresp = rd_hit ? clk_gate_pkg::RESP_OKAY : clk_gate_pkg::RESP_SLVERR;
      next_rdata = '0;
      if (is_reg(araddr_i, clk_gate_pkg::OFF_RUN_GATE)) begin
        next_rdata = run_gate;
      end
      if (is_reg(araddr_i, clk_gate_pkg::OFF_SLEEP_GATE)) begin
        next_rdata = sleep_gate;
      end
      if (is_reg(araddr_i, clk_gate_pkg::OFF_DEEP_GATE)) begin
        next_rdata = deep_gate;
      end
      if (is_reg(araddr_i, clk_gate_pkg::OFF_MODE_CFG)) begin
        next_rdata[clk_gate_pkg::AUTO_SLEEP_BIT] = auto_sleep_gating_select;
      end
      if (is_reg(araddr_i, clk_gate_pkg::OFF_IRQ_STATUS)) begin
        next_rdata[clk_gate_pkg::IRQ_W-1:0] = irq_status;
      end
      if (is_reg(araddr_i, clk_gate_pkg::OFF_IRQ_MASK)) begin
        next_rdata[clk_gate_pkg::IRQ_W-1:0] = irq_mask;
      end
    end else if (rd_state == clk_gate_pkg::RD_RESP && rready_i) begin
      next_rd_state = clk_gate_pkg::RD_IDLE;
    end

    // a new event in the clearing cycle survives the clear
    irq_set = '0;
    irq_set[clk_gate_pkg::IRQ_ACCESS_FAULT] = periph_fault_o;
    irq_set[clk_gate_pkg::IRQ_BAD_ADDRESS] = (do_write && !wr_hit) || (ar_take && !rd_hit);
    next_irq_status = (irq_status & ~irq_clear) | irq_set;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_state <= clk_gate_pkg::WR_IDLE;
      rd_state <= clk_gate_pkg::RD_IDLE;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      bresp <= clk_gate_pkg::RESP_OKAY;
      rdata <= '0;
      rresp <= clk_gate_pkg::RESP_OKAY;
      run_gate <= clk_gate_pkg::GATE_RESET;
      sleep_gate <= clk_gate_pkg::GATE_RESET;
      deep_gate <= clk_gate_pkg::GATE_RESET;
      auto_sleep_gating_select <= clk_gate_pkg::AUTO_SLEEP_RESET;
      irq_status <= clk_gate_pkg::IRQ_RESET;
      irq_mask <= clk_gate_pkg::IRQ_RESET;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= next_bresp;
      rdata <= next_rdata;
      rresp <= next_rresp;
      run_gate <= next_run_gate;
      sleep_gate <= next_sleep_gate;
      deep_gate <= next_deep_gate;
      auto_sleep_gating_select <= next_auto_sleep_gating_select;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  assign bvalid_o = (wr_state == clk_gate_pkg::WR_RESP);
  assign bresp_o = bresp;
  assign rvalid_o = (rd_state == clk_gate_pkg::RD_RESP);
  assign rdata_o = rdata;
  assign rresp_o = rresp;
  assign irq_o = |(irq_status & irq_mask);

  // =====================================================================
  // gating selection and unit enables
  // =====================================================================
  // without auto gating the run setting stays in force while asleep
  always_comb begin
    want_en = clk_gate_pkg::pack_units(run_gate);
    if (auto_sleep_gating_select && deep_sleep_i) begin
      want_en = clk_gate_pkg::pack_units(deep_gate);
    end else if (auto_sleep_gating_select && sleep_i) begin
      want_en = clk_gate_pkg::pack_units(sleep_gate);
    end
  end

  unit_clock_enable #(
    .UNITS(UNITS)
  ) u_enable (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .en_i(want_en),
    .en_o(unit_clk_en_o)
  );

  peripheral_access_guard #(
    .UNITS(UNITS)
  ) u_guard (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .gate_i(unit_clk_en_o),
    .req_i(periph_req_i),
    .unit_i(periph_unit_i),
    .grant_o(periph_grant_o),
    .fault_o(periph_fault_o)
  );

  // =====================================================================
  // checks
  // =====================================================================
  chk_reset_gates_zero: assert property (@(posedge clock_i) $fell(rst_i) |-> run_gate == 32'h0000_0000)
    else $error("run gating not zero after reset");

  chk_reserved_read_zero: assert property (@(posedge clock_i) disable iff (rst_i)
      (ar_take && is_reg(araddr_i, clk_gate_pkg::OFF_RUN_GATE)) |=> (rdata_o & ~32'h0107_1133) == '0)
    else $error("reserved gate bits read nonzero");

  chk_comp_bit_write: assert property (@(posedge clock_i) disable iff (rst_i)
      (do_write && is_reg(wr_addr, 12'h104) && wr_strb[3]) |=> run_gate[24] == $past(wr_data[24]))
    else $error("comparator gate bit not written");

  chk_counter_bits: assert property (@(posedge clock_i) disable iff (rst_i)
      (do_write && is_reg(wr_addr, 12'h104) && wr_strb[2]) |=> run_gate[18:16] == $past(wr_data[18:16]))
    else $error("counter gate bits not written");

  chk_serial_bits: assert property (@(posedge clock_i) disable iff (rst_i)
      (do_write && is_reg(wr_addr, 12'h104) && wr_strb[1] && wr_strb[0]) |=>
      {run_gate[12], run_gate[8], run_gate[5:4], run_gate[1:0]} ==
      $past({wr_data[12], wr_data[8], wr_data[5:4], wr_data[1:0]}))
    else $error("serial unit gate bits not written");

  chk_sleep_reg_write: assert property (@(posedge clock_i) disable iff (rst_i)
      (do_write && is_reg(wr_addr, 12'h114) && wr_strb[3]) |=> sleep_gate[24] == $past(wr_data[24]))
    else $error("sleep gating register not written");

  chk_run_drives_units: assert property (@(posedge clock_i) disable iff (rst_i)
      (!auto_sleep_gating_select || (!sleep_i && !deep_sleep_i)) |=>
      unit_clk_en_o == clk_gate_pkg::pack_units($past(run_gate)))
    else $error("unit enables do not follow run gating");

  chk_gate_change_lag: assert property (@(posedge clock_i) disable iff (rst_i)
      (bvalid_o && bready_i && !auto_sleep_gating_select) |->
      ##1 unit_clk_en_o == clk_gate_pkg::pack_units($past(run_gate)))
    else $error("gate change not applied after write");

endmodule : run_mode_clock_gate_bank1

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] awaddr_i = 12'h000;
  logic awvalid_i = 1'b0;
  logic awready_o;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic [3:0] wstrb_i = 4'h0;
  logic wvalid_i = 1'b0;
  logic wready_o;
  logic [1:0] bresp_o;
  logic bvalid_o;
  logic bready_i = 1'b1;
  logic [11:0] araddr_i = 12'h000;
  logic arvalid_i = 1'b0;
  logic arready_o;
  logic [31:0] rdata_o;
  logic [1:0] rresp_o;
  logic rvalid_o;
  logic rready_i = 1'b1;
  logic sleep_i = 1'b0;
  logic deep_sleep_i = 1'b0;
  logic periph_req_i = 1'b0;
  logic [3:0] periph_unit_i = 4'h0;
  logic periph_grant_o;
  logic periph_fault_o;
  logic [9:0] unit_clk_en_o;
  logic irq_o;
  int fail_count = 0;
  int checks_done = 0;
  logic [33:0] read_notes[$];
  logic [1:0] write_notes[$];
  logic [31:0] rnd = 32'h0000_0007;
  logic [31:0] run_model;

  run_mode_clock_gate_bank1 u_dut (.clock_i(clock_i), .rst_i(rst_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i), .periph_req_i(periph_req_i), .periph_unit_i(periph_unit_i),
    .periph_grant_o(periph_grant_o), .periph_fault_o(periph_fault_o), .unit_clk_en_o(unit_clk_en_o), .irq_o(irq_o));

  always #2.5 clock_i = ~clock_i;

  // =====================================================================
  // comparison and verdict
  // =====================================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  // responses are compared in the order they were issued
  always @(posedge clock_i) begin
    if (!rst_i && rvalid_o && rready_i && read_notes.size() > 0) begin
      logic [33:0] e;
      e = read_notes.pop_front();
      check("rdata", rdata_o, e[31:0]);
      check("rresp", 32'(rresp_o), 32'(e[33:32]));
    end
    if (!rst_i && bvalid_o && bready_i && write_notes.size() > 0) begin
      logic [1:0] e;
      e = write_notes.pop_front();
      check("bresp", 32'(bresp_o), 32'(e));
    end
  end

  // =====================================================================
  // bus master; readies sampled at the falling edge hold at the next rise
  // =====================================================================
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_done, w_done, awr, wrd, bv;
    aw_done = 1'b0;
    w_done = 1'b0;
    bv = 1'b0;
    write_notes.push_back(er);
    awaddr_i <= a;
    wdata_i <= d;
    wstrb_i <= s;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clock_i);
      awr = awready_o;
      wrd = wready_o;
      @(posedge clock_i);
      if (awr && !aw_done) begin
        awvalid_i <= 1'b0;
        aw_done = 1'b1;
      end
      if (wrd && !w_done) begin
        wvalid_i <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!bv) begin
      @(negedge clock_i);
      bv = bvalid_o;
      @(posedge clock_i);
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic arr, rv;
    arr = 1'b0;
    rv = 1'b0;
    read_notes.push_back({er, ed});
    araddr_i <= a;
    arvalid_i <= 1'b1;
    while (!arr) begin
      @(negedge clock_i);
      arr = arready_o;
      @(posedge clock_i);
    end
    arvalid_i <= 1'b0;
    while (!rv) begin
      @(negedge clock_i);
      rv = rvalid_o;
      @(posedge clock_i);
    end
  endtask : rd

  // levels are looked at once registered updates have landed
  task automatic expect_en(input logic [9:0] exp, input logic exp_irq);
    repeat (2) @(negedge clock_i);
    check("unit_clk_en", 32'(unit_clk_en_o), 32'(exp));
    check("irq", 32'(irq_o), 32'(exp_irq));
    @(posedge clock_i);
  endtask : expect_en

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
  endtask : do_reset

  // =====================================================================
  // scenarios
  // =====================================================================
  initial begin
    logic [31:0] v;
    logic [3:0] s;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rd(clk_gate_pkg::OFF_RUN_GATE, clk_gate_pkg::GATE_RESET, clk_gate_pkg::RESP_OKAY);
    expect_en(10'h000, 1'b0);
    wr(clk_gate_pkg::OFF_RUN_GATE, 32'hffff_ffff, 4'hf, clk_gate_pkg::RESP_OKAY);
    expect_en(10'h3ff, 1'b0);
    rd(clk_gate_pkg::OFF_RUN_GATE, 32'h0107_1133, clk_gate_pkg::RESP_OKAY);
    $display("test reset_and_layout done");
    for (int k = 0; k < clk_gate_pkg::UNIT_COUNT; k++) begin
      v = 32'h1 << clk_gate_pkg::UNIT_BIT[k];
      wr(clk_gate_pkg::OFF_RUN_GATE, v, 4'hf, clk_gate_pkg::RESP_OKAY);
      rd(clk_gate_pkg::OFF_RUN_GATE, v, clk_gate_pkg::RESP_OKAY);
      expect_en(10'h1 << k, 1'b0);
      for (int u = 0; u < 16; u++) begin
        periph_req_i <= 1'b1;
        periph_unit_i <= 4'(u);
        @(negedge clock_i);
        check("grant", 32'(periph_grant_o), 32'(u == k));
        check("fault", 32'(periph_fault_o), 32'(u != k));
        @(posedge clock_i);
      end
      periph_req_i <= 1'b0;
    end
    $display("test unit_gating done");
    // last unit written above was the comparator alone
    run_model = 32'h0100_0000;
    for (int n = 0; n < 8; n++) begin
      rnd = lfsr_next(rnd);
      v = rnd;
      rnd = lfsr_next(rnd);
      s = rnd[3:0];
      for (int b = 0; b < 4; b++) begin
        if (s[b]) begin
          run_model[8*b +: 8] = v[8*b +: 8];
        end
      end
      run_model = run_model & 32'h0107_1133;
      wr(clk_gate_pkg::OFF_RUN_GATE, v, s, clk_gate_pkg::RESP_OKAY);
      rd(clk_gate_pkg::OFF_RUN_GATE, run_model, clk_gate_pkg::RESP_OKAY);
    end
    $display("test random_strobes done");
    wr(clk_gate_pkg::OFF_RUN_GATE, 32'h0000_0003, 4'hf, clk_gate_pkg::RESP_OKAY);
    wr(clk_gate_pkg::OFF_SLEEP_GATE, 32'h0000_0030, 4'hf, clk_gate_pkg::RESP_OKAY);
    wr(clk_gate_pkg::OFF_DEEP_GATE, 32'h0100_0000, 4'hf, clk_gate_pkg::RESP_OKAY);
    rd(clk_gate_pkg::OFF_SLEEP_GATE, 32'h0000_0030, clk_gate_pkg::RESP_OKAY);
    rd(clk_gate_pkg::OFF_DEEP_GATE, 32'h0100_0000, clk_gate_pkg::RESP_OKAY);
    // mask is still at reset, so the faults seen earlier stay silent
    sleep_i <= 1'b1;
    expect_en(10'h003, 1'b0);
    wr(clk_gate_pkg::OFF_MODE_CFG, 32'h0000_0001, 4'hf, clk_gate_pkg::RESP_OKAY);
    rd(clk_gate_pkg::OFF_MODE_CFG, 32'h0000_0001, clk_gate_pkg::RESP_OKAY);
    expect_en(10'h00c, 1'b0);
    deep_sleep_i <= 1'b1;
    expect_en(10'h200, 1'b0);
    sleep_i <= 1'b0;
    deep_sleep_i <= 1'b0;
    expect_en(10'h003, 1'b0);
    $display("test sleep_selection done");
    do_reset();
    rd(clk_gate_pkg::OFF_IRQ_STATUS, 32'h0000_0000, clk_gate_pkg::RESP_OKAY);
    periph_req_i <= 1'b1;
    periph_unit_i <= 4'h4;
    @(posedge clock_i);
    periph_req_i <= 1'b0;
    expect_en(10'h000, 1'b0);
    wr(clk_gate_pkg::OFF_IRQ_MASK, 32'h0000_0003, 4'hf, clk_gate_pkg::RESP_OKAY);
    rd(clk_gate_pkg::OFF_IRQ_MASK, 32'h0000_0003, clk_gate_pkg::RESP_OKAY);
    expect_en(10'h000, 1'b1);
    rd(12'h200, 32'h0000_0000, clk_gate_pkg::RESP_SLVERR);
    wr(12'h208, 32'hffff_ffff, 4'hf, clk_gate_pkg::RESP_SLVERR);
    rd(clk_gate_pkg::OFF_IRQ_STATUS, 32'h0000_0003, clk_gate_pkg::RESP_OKAY);
    wr(clk_gate_pkg::OFF_IRQ_STATUS, 32'h0000_0001, 4'hf, clk_gate_pkg::RESP_OKAY);
    rd(clk_gate_pkg::OFF_IRQ_STATUS, 32'h0000_0002, clk_gate_pkg::RESP_OKAY);
    wr(clk_gate_pkg::OFF_IRQ_STATUS, 32'h0000_0002, 4'hf, clk_gate_pkg::RESP_OKAY);
    expect_en(10'h000, 1'b0);
    rd(clk_gate_pkg::OFF_RUN_GATE, 32'h0000_0000, clk_gate_pkg::RESP_OKAY);
    $display("test faults_and_irq done");
    repeat (4) @(posedge clock_i);
    results();
  end

  // whole run needs a few hundred cycles; the limit leaves wide margin
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule : testbench

`default_nettype wire
